/* File: design/urxf_pkg.sv */
// Package for the receive FIFO error flag block: register map, field positions, reset values and sizes.
// Assumes a 32-bit APB slave with one aligned word per register.
package urxf_pkg;
  // Printed offsets are not all multiples of four, so they are indices and byte address is four times the index.
  localparam logic [7:0]  FLAGS_INDEX     = 8'h09;
  localparam logic [7:0]  CONTROL_INDEX   = 8'h0A;
  localparam logic [7:0]  DATA_INDEX      = 8'h0B;
  localparam logic [7:0]  CNT_LOW_INDEX   = 8'h0C;
  localparam logic [7:0]  CNT_HIGH_INDEX  = 8'h0D;
  localparam logic [7:0]  INT_STAT_INDEX  = 8'h0E;
  localparam logic [7:0]  INT_MASK_INDEX  = 8'h0F;
  localparam logic [7:0]  MODE_INDEX      = 8'h10;
  // Field positions in the flag register.
  localparam int          OVF_BIT         = 0;
  localparam int          URF_BIT         = 1;
  localparam int          FULL_BIT        = 2;
  localparam int          EMP_BIT         = 3;
  localparam int          SETCNT_LSB      = 6;
  // Field positions in the control register.
  localparam int          CLEAR_BIT       = 0;
  localparam int          READ_DONE_BIT   = 1;
  // Field position in the mode register.
  localparam int          ISO_BIT         = 0;
  // Reset values.
  localparam logic [7:0]  FLAGS_RESET     = 8'h08;
  localparam logic [1:0]  INT_MASK_RESET  = 2'h0;
  localparam logic        ISO_RESET       = 1'b0;
  // FIFO sizes.
  localparam int          DEPTH           = 16;
  localparam int          PTR_W           = 4;
  localparam logic [1:0]  SETCNT_EMPTY    = 2'h0;
  localparam logic [1:0]  SETCNT_FULL     = 2'h3;
endpackage

/* File: design/urxf_sticky.sv */
// Sticky flag with deferred-set option and synchronous clear; set wins over clear.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/10ps
module urxf_sticky
(
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic set_now,
  input  wire logic set_late,
  input  wire logic release_late,
  input  wire logic clear,
  output logic      flag
);
  logic pending_reg;

  // A deferred event waits here until its release strobe.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      pending_reg <= 1'b0;
    else if (set_late)
      pending_reg <= 1'b1;
    else if (release_late || clear)
      pending_reg <= 1'b0;
  end

  // The flag only falls on an explicit clear, and a same-cycle set keeps it high.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      flag <= 1'b0;
    else if (set_now || (release_late && pending_reg))
      flag <= 1'b1;
    else if (clear)
      flag <= 1'b0;
  end
endmodule

/* File: design/urxf_apb.sv */
// APB slave front end: decodes word indices and gives one-cycle read and write strobes.
// Assumes APB3 with zero wait states; pready is always high.
`timescale 1ns/10ps
module urxf_apb
(
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  output logic             pready,
  output logic             pslverr,
  output logic             wr_stb,
  output logic             rd_stb,
  output logic [7:0]       index,
  output logic             aligned
);
  // Every access finishes in its first access cycle, so strobes fire exactly once.
  assign pready  = 1'b1;
  assign index   = paddr[9:2];
  assign aligned = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
  assign wr_stb  = psel && penable && pwrite;
  assign rd_stb  = psel && penable && !pwrite;
  // Unaligned or out-of-range addresses get an error answer and no effect.
  assign pslverr = psel && penable && !aligned;
endmodule

/* File: design/urxf_top.sv */
// Receive FIFO with underrun and overrun error tracking, APB register access and interrupt.
// Assumes the serial engine drives byte writes, byte-count writes, SETUP and SOF pulses on clk.
`timescale 1ns/10ps
module urxf_top
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  input  wire logic        eng_byte_valid,
  input  wire logic [7:0]  eng_byte,
  input  wire logic        eng_count_valid,
  input  wire logic [9:0]  eng_count,
  input  wire logic        eng_setup,
  input  wire logic        eng_sof,
  output logic             force_nak,
  output logic             irq
);
  typedef enum logic [1:0] {URXF_IDLE = 2'b01, URXF_ERROR = 2'b10} urxf_state_t;

  logic                        wr_stb;
  logic                        rd_stb;
  logic [7:0]                  index;
  logic                        aligned;
  logic [7:0]                  mem_reg [urxf_pkg::DEPTH];
  logic [urxf_pkg::PTR_W:0]    wptr_reg;
  logic [urxf_pkg::PTR_W:0]    rptr_reg;
  logic [1:0]                  setcnt_reg;
  logic                        iso_pend_reg;
  logic [9:0]                  count_reg;
  logic                        iso_reg;
  logic [1:0]                  int_stat_reg;
  logic [1:0]                  int_mask_reg;
  logic                        urf;
  logic                        ovf;
  logic                        fifo_empty;
  logic                        fifo_full;
  logic                        clear_cmd;
  logic                        read_done_cmd;
  logic                        data_rd;
  logic                        cnt_rd;
  logic                        underrun_ev;
  logic                        overrun_ev;
  logic                        ovf_late;
  logic                        set_arrival;
  logic                        setcnt_inc;
  logic                        setcnt_dec;
  logic [1:0]                  int_rd_clr;
  logic                        urf_d_reg;
  logic                        ovf_d_reg;
  logic                        urf_rise;
  logic                        ovf_rise;
  logic [7:0]                  flags_view;
  logic [31:0]                 rd_mux;
  urxf_state_t                 state_reg;

  urxf_apb u_apb
  (
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pready  (pready),
    .pslverr (pslverr),
    .wr_stb  (wr_stb),
    .rd_stb  (rd_stb),
    .index   (index),
    .aligned (aligned)
  );

  // Decoded firmware actions.
  assign clear_cmd     = wr_stb && aligned && (index == urxf_pkg::CONTROL_INDEX) && pwdata[urxf_pkg::CLEAR_BIT];
  assign read_done_cmd = wr_stb && aligned && (index == urxf_pkg::CONTROL_INDEX) && pwdata[urxf_pkg::READ_DONE_BIT];
  assign data_rd       = rd_stb && aligned && (index == urxf_pkg::DATA_INDEX);
  assign cnt_rd        = rd_stb && aligned
                         && ((index == urxf_pkg::CNT_LOW_INDEX) || (index == urxf_pkg::CNT_HIGH_INDEX));
  assign fifo_empty    = (wptr_reg == rptr_reg);
  assign fifo_full     = (wptr_reg[urxf_pkg::PTR_W] != rptr_reg[urxf_pkg::PTR_W])
                         && (wptr_reg[urxf_pkg::PTR_W-1:0] == rptr_reg[urxf_pkg::PTR_W-1:0]);

  // Error events; underrun is firmware-caused and never deferred.
  assign underrun_ev = (data_rd && fifo_empty) || (cnt_rd && (setcnt_reg == urxf_pkg::SETCNT_EMPTY));
  assign overrun_ev  = (eng_byte_valid && fifo_full)
                       || (eng_count_valid && (setcnt_reg == urxf_pkg::SETCNT_FULL));
  assign ovf_late    = overrun_ev && iso_reg;
  assign set_arrival = eng_count_valid && (setcnt_reg != urxf_pkg::SETCNT_FULL);

  // Data-set count steps and the read-clear of interrupt status, kept out of the clocked processes.
  assign setcnt_inc = (set_arrival && !iso_reg) || (eng_sof && iso_pend_reg);
  assign setcnt_dec = read_done_cmd && (setcnt_reg != urxf_pkg::SETCNT_EMPTY);
  assign int_rd_clr = (rd_stb && aligned && (index == urxf_pkg::INT_STAT_INDEX)) ? 2'h3 : 2'h0;

  // Underrun flag: sticky, cleared only by the FIFO clear control.
  urxf_sticky u_urf
  (
    .clk          (clk),
    .resetn       (resetn),
    .set_now      (underrun_ev),
    .set_late     (1'b0),
    .release_late (eng_sof), // Harmless: nothing is ever armed for a deferred underrun.
    .clear        (clear_cmd),
    .flag         (urf)
  );

  // Overrun flag: deferred to SOF in isochronous mode, cleared by clear or by a later SETUP.
  urxf_sticky u_ovf
  (
    .clk          (clk),
    .resetn       (resetn),
    .set_now      (overrun_ev && !iso_reg),
    .set_late     (ovf_late),
    .release_late (eng_sof),
    .clear        (clear_cmd || (eng_setup && ovf)),
    .flag         (ovf)
  );

  // Error state tracks whether the endpoint must NAK.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      state_reg <= URXF_IDLE;
    else
    begin
      case (state_reg)
        URXF_IDLE:
          if (urf || ovf)
            state_reg <= URXF_ERROR;
        URXF_ERROR:
          if (!urf && !ovf)
            state_reg <= URXF_IDLE;
        default:
          state_reg <= URXF_IDLE;
      endcase
    end
  end

  // NAK follows the flags directly so no transaction slips through while the state catches up.
  assign force_nak = urf || ovf || (state_reg == URXF_ERROR);

  // Write pointer and storage; a byte into a full FIFO leaves the pointer at full.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      wptr_reg <= '0;
    else if (clear_cmd)
      wptr_reg <= '0;
    else if (eng_byte_valid && !fifo_full)
      wptr_reg <= wptr_reg + 1'b1;
  end

  // Data storage is written only while space remains.
  always_ff @(posedge clk)
  begin
    if (eng_byte_valid && !fifo_full)
      mem_reg[wptr_reg[urxf_pkg::PTR_W-1:0]] <= eng_byte;
  end

  // Read pointer; a read from empty locks it at the empty position.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rptr_reg <= '0;
    else if (clear_cmd)
      rptr_reg <= '0;
    else if (data_rd && !fifo_empty)
      rptr_reg <= rptr_reg + 1'b1;
  end

  // Byte count of the latest accepted data set.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      count_reg <= '0;
    else if (clear_cmd)
      count_reg <= '0;
    else if (set_arrival)
      count_reg <= eng_count;
  end

  // Isochronous arrivals are held until SOF before the data-set count rises.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      iso_pend_reg <= 1'b0;
    else if (clear_cmd)
      iso_pend_reg <= 1'b0;
    else if (set_arrival && iso_reg)
      iso_pend_reg <= 1'b1;
    else if (eng_sof)
      iso_pend_reg <= 1'b0;
  end

  // Data-set count: rises on an arrival, falls on read-complete; both in one cycle cancel.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      setcnt_reg <= urxf_pkg::SETCNT_EMPTY;
    else if (clear_cmd)
      setcnt_reg <= urxf_pkg::SETCNT_EMPTY;
    else if (setcnt_inc && !setcnt_dec && (setcnt_reg != urxf_pkg::SETCNT_FULL))
      setcnt_reg <= setcnt_reg + 2'h1;
    else if (setcnt_dec && !setcnt_inc)
      setcnt_reg <= setcnt_reg - 2'h1;
  end

  // Mode and interrupt mask registers.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      iso_reg      <= urxf_pkg::ISO_RESET;
      int_mask_reg <= urxf_pkg::INT_MASK_RESET;
    end
    else if (wr_stb && aligned)
    begin
      if (index == urxf_pkg::MODE_INDEX)
        iso_reg <= pwdata[urxf_pkg::ISO_BIT];
      if (index == urxf_pkg::INT_MASK_INDEX)
        int_mask_reg <= pwdata[1:0];
    end
  end

  // Interrupt status: rising flags set bits, a read clears them, and a new set wins.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      int_stat_reg <= 2'h0;
    else
      int_stat_reg <= (int_stat_reg & ~int_rd_clr) | {urf_rise, ovf_rise};
  end

  // Edge history of the error flags feeds the interrupt status.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      urf_d_reg <= 1'b0;
      ovf_d_reg <= 1'b0;
    end
    else
    begin
      urf_d_reg <= urf;
      ovf_d_reg <= ovf;
    end
  end

  assign urf_rise = urf && !urf_d_reg;
  assign ovf_rise = ovf && !ovf_d_reg;
  assign irq      = |(int_stat_reg & int_mask_reg);

  // Flag register view; empty and full track the FIFO in every mode.
  always_comb
  begin
    flags_view = 8'h00;
    flags_view[urxf_pkg::OVF_BIT]              = ovf;
    flags_view[urxf_pkg::URF_BIT]              = urf;
    flags_view[urxf_pkg::FULL_BIT]             = fifo_full;
    flags_view[urxf_pkg::EMP_BIT]              = fifo_empty;
    flags_view[urxf_pkg::SETCNT_LSB+1 -: 2]    = setcnt_reg;
  end

  // Read data mux; unmapped indices read zero.
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (index)
      urxf_pkg::FLAGS_INDEX:    rd_mux = {24'h000000, flags_view};
      urxf_pkg::DATA_INDEX:     rd_mux = fifo_empty ? 32'h0000_0000
                                         : {24'h000000, mem_reg[rptr_reg[urxf_pkg::PTR_W-1:0]]};
      urxf_pkg::CNT_LOW_INDEX:  rd_mux = {24'h000000, count_reg[7:0]};
      urxf_pkg::CNT_HIGH_INDEX: rd_mux = {30'h0, count_reg[9:8]};
      urxf_pkg::INT_STAT_INDEX: rd_mux = {30'h0, int_stat_reg};
      urxf_pkg::INT_MASK_INDEX: rd_mux = {30'h0, int_mask_reg};
      urxf_pkg::MODE_INDEX:     rd_mux = {31'h0, iso_reg};
      default:                  rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data is registered in the setup cycle so it stands valid through the access phase.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= aligned ? rd_mux : 32'h0000_0000;
  end

  // Properties.
  property p_urf_set;
    @(posedge clk) disable iff (!resetn) underrun_ev |=> urf;
  endproperty
  a_urf_set: assert property (p_urf_set) else $error("underrun not flagged");
  property p_urf_sticky;
    @(posedge clk) disable iff (!resetn) (urf && !clear_cmd) |=> urf;
  endproperty
  a_urf_sticky: assert property (p_urf_sticky) else $error("underrun dropped without clear");
  property p_rptr_hold;
    @(posedge clk) disable iff (!resetn) (data_rd && fifo_empty && !clear_cmd) |=> $stable(rptr_reg);
  endproperty
  a_rptr_hold: assert property (p_rptr_hold) else $error("read pointer moved on underrun");
  property p_nak;
    @(posedge clk) disable iff (!resetn) (urf || ovf) |-> force_nak;
  endproperty
  a_nak: assert property (p_nak) else $error("no NAK while error set");
  property p_iso_ovf_defer;
    @(posedge clk) disable iff (!resetn) (iso_reg && !ovf && !eng_sof) |=> !ovf;
  endproperty
  a_iso_ovf_defer: assert property (p_iso_ovf_defer) else $error("iso overrun set before SOF");
  property p_ovf_set;
    @(posedge clk) disable iff (!resetn) (overrun_ev && !iso_reg) |=> ovf;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overrun not flagged");
  property p_ovf_setup_clr;
    @(posedge clk) disable iff (!resetn) (ovf && eng_setup && !overrun_ev && !eng_sof) |=> !ovf;
  endproperty
  a_ovf_setup_clr: assert property (p_ovf_setup_clr) else $error("SETUP did not clear overrun");
  property p_wptr_hold;
    @(posedge clk) disable iff (!resetn) (eng_byte_valid && fifo_full && !clear_cmd) |=> $stable(wptr_reg);
  endproperty
  a_wptr_hold: assert property (p_wptr_hold) else $error("write pointer moved on overrun");
  property p_clear_all;
    @(posedge clk) disable iff (!resetn) (clear_cmd && !underrun_ev && !overrun_ev) |=>
      (!urf && wptr_reg == '0 && rptr_reg == '0 && setcnt_reg == urxf_pkg::SETCNT_EMPTY);
  endproperty
  a_clear_all: assert property (p_clear_all) else $error("clear incomplete");
  c_underrun: cover property (@(posedge clk) disable iff (!resetn) underrun_ev);
  c_iso_ovf:  cover property (@(posedge clk) disable iff (!resetn) ovf_late ##[1:100] eng_sof);
  c_setup:    cover property (@(posedge clk) disable iff (!resetn) ovf && eng_setup);
endmodule

/* File: verification/urxf_engine_model.sv */
// Behavioural serial engine: byte, byte-count, SETUP and SOF strobes for the receive FIFO.
// Assumes the bench calls one task at a time; every change lands just after a rising edge of clk.
`timescale 1ns/10ps
module urxf_engine_model
(
  input  wire logic clk,
  output logic      eng_byte_valid,
  output logic [7:0] eng_byte,
  output logic      eng_count_valid,
  output logic [9:0] eng_count,
  output logic      eng_setup,
  output logic      eng_sof
);
  // Strobes idle low; data lines start at a pattern that is not a plausible value.
  initial
  begin
    eng_byte_valid  = 1'b0;
    eng_byte        = 8'h5A;
    eng_count_valid = 1'b0;
    eng_count       = 10'h2A5;
    eng_setup       = 1'b0;
    eng_sof         = 1'b0;
  end

  // A released data line shows the inverse, so a design that samples late never sees the old value.
  task send_byte(input logic [7:0] b);
    @(posedge clk);
    eng_byte_valid <= 1'b1;
    eng_byte       <= b;
    @(posedge clk);
    eng_byte_valid <= 1'b0;
    eng_byte       <= ~b;
  endtask

  // A count marks the end of one valid data set.
  task send_count(input logic [9:0] c);
    @(posedge clk);
    eng_count_valid <= 1'b1;
    eng_count       <= c;
    @(posedge clk);
    eng_count_valid <= 1'b0;
    eng_count       <= ~c;
  endtask

  // One-cycle token pulse: SETUP when sof is low, start of frame when it is high.
  task pulse(input logic sof);
    @(posedge clk);
    eng_setup <= ~sof;
    eng_sof   <= sof;
    @(posedge clk);
    eng_setup <= 1'b0;
    eng_sof   <= 1'b0;
  endtask
endmodule

/* File: verification/usb_rx_fifo_error_flags_test.sv */
// Self-checking bench for the receive FIFO error flags, driven over APB and the engine model.
// Assumes the APB slave answers without wait states but still waits for pready under a bound.
`timescale 1ns/10ps
module usb_rx_fifo_error_flags_test;
  logic        clk;
  logic        resetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] prdata;
  logic        eng_byte_valid;
  logic [7:0]  eng_byte;
  logic        eng_count_valid;
  logic [9:0]  eng_count;
  logic        eng_setup;
  logic        eng_sof;
  logic        force_nak;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  int          fails;
  int          check_count;
  // Byte addresses are four times the register index.
  localparam logic [11:0] AF = {2'h0, urxf_pkg::FLAGS_INDEX, 2'h0};
  localparam logic [11:0] AC = {2'h0, urxf_pkg::CONTROL_INDEX, 2'h0};
  localparam logic [11:0] AD = {2'h0, urxf_pkg::DATA_INDEX, 2'h0};
  localparam logic [11:0] AL = {2'h0, urxf_pkg::CNT_LOW_INDEX, 2'h0};
  localparam logic [11:0] AH = {2'h0, urxf_pkg::CNT_HIGH_INDEX, 2'h0};
  localparam logic [11:0] AS = {2'h0, urxf_pkg::INT_STAT_INDEX, 2'h0};
  localparam logic [11:0] AM = {2'h0, urxf_pkg::INT_MASK_INDEX, 2'h0};
  localparam logic [11:0] AO = {2'h0, urxf_pkg::MODE_INDEX, 2'h0};

  urxf_top dut_u (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .eng_byte_valid(eng_byte_valid), .eng_byte(eng_byte), .eng_count_valid(eng_count_valid),
    .eng_count(eng_count), .eng_setup(eng_setup), .eng_sof(eng_sof), .force_nak(force_nak), .irq(irq));

  urxf_engine_model eng_u (.clk(clk), .eng_byte_valid(eng_byte_valid), .eng_byte(eng_byte),
    .eng_count_valid(eng_count_valid), .eng_count(eng_count), .eng_setup(eng_setup), .eng_sof(eng_sof));

  // Free-running clock at 20 MHz.
  always #25 clk = ~clk;

  task report_and_stop;
    if (fails == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      $display("MISMATCH %s expected %0h seen %0h", n, exp, seen);
      fails++;
    end
  endtask

  // One APB transfer; request held until pready is sampled high, read data taken at that edge.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      fails++;
      report_and_stop();
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task rdc(input string n, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, rd & m, e);
  endtask

  // Single data set, read past its end, then read-complete and clear.
  task t_underrun;
    rdc("flags_reset", AF, 32'hFF, {24'h0, urxf_pkg::FLAGS_RESET});
    eng_u.send_byte(8'hA5);
    eng_u.send_count(10'h001);
    rdc("count_low", AL, 32'hFF, 32'h01);
    rdc("data", AD, 32'hFF, 32'hA5);
    rdc("flags_ok", AF, 32'h03, 32'h00);
    apb(1'b0, AD, 32'h0);
    @(negedge clk);
    chk("nak_urf", force_nak, 32'h1);
    rdc("flags_urf", AF, 32'hFF, 32'h4A);
    apb(1'b1, AC, 32'h2);
    rdc("flags_sticky", AF, 32'hFF, 32'h0A);
    apb(1'b1, AC, 32'h1);
    rdc("flags_clr", AF, 32'hFF, 32'h08);
    rdc("count_empty", AL, 32'hFF, 32'h0);
    rdc("flags_cnt_urf", AF, 32'h02, 32'h02);
    apb(1'b1, AC, 32'h1);
    rdc("count_high", AH, 32'hFF, 32'h0);
    rdc("flags_cnth_urf", AF, 32'h02, 32'h02);
    apb(1'b1, AC, 32'h1);
  endtask

  // Seventeen bytes into a sixteen-byte FIFO; the last must be dropped.
  task t_overrun;
    for (int i = 0; i < 17; i++)
      eng_u.send_byte(i[7:0]);
    rdc("flags_ovf", AF, 32'h07, 32'h05);
    @(negedge clk);
    chk("nak_ovf", force_nak, 32'h1);
    eng_u.send_count(10'h010);
    for (int i = 0; i < 16; i++)
      rdc("data_kept", AD, 32'hFF, i);
    eng_u.pulse(1'b0);
    rdc("flags_setup", AF, 32'h01, 32'h00);
    apb(1'b1, AC, 32'h1);
    for (int i = 0; i < 4; i++)
      eng_u.send_count(10'h001);
    rdc("flags_cnt_ovf", AF, 32'hC1, 32'hC1);
    apb(1'b1, AC, 32'h1);
    rdc("flags_clr2", AF, 32'hFF, 32'h08);
    @(negedge clk);
    chk("nak_clr", force_nak, 32'h0);
  endtask

  // Isochronous mode: engine-caused overrun and data-set count changes wait for SOF, firmware-caused ones do not.
  task t_iso;
    apb(1'b1, AO, 32'h1);
    for (int i = 0; i < 17; i++)
      eng_u.send_byte(8'hC3);
    eng_u.send_count(10'h010);
    rdc("iso_before_sof", AF, 32'hC1, 32'h00);
    @(negedge clk);
    chk("iso_nak", force_nak, 32'h0);
    eng_u.pulse(1'b1);
    rdc("iso_after_sof", AF, 32'hC1, 32'h41);
    apb(1'b1, AC, 32'h1);
    rdc("iso_count_low", AL, 32'hFF, 32'h0);
    rdc("iso_urf_now", AF, 32'h03, 32'h02);
    apb(1'b1, AC, 32'h1);
    apb(1'b1, AO, 32'h0);
  endtask

  // Interrupt raised, read-cleared, and masked.
  task t_irq;
    apb(1'b1, AM, 32'h0);
    apb(1'b0, AS, 32'h0);
    apb(1'b1, AM, 32'h2);
    apb(1'b0, AD, 32'h0);
    // The flag rises at the edge that ends the read and the status bit one edge later.
    repeat (2) @(negedge clk);
    chk("irq_on", irq, 32'h1);
    rdc("int_stat", AS, 32'h3, 32'h2);
    @(negedge clk);
    chk("irq_off", irq, 32'h0);
    apb(1'b1, AC, 32'h1);
    apb(1'b1, AM, 32'h1);
    apb(1'b0, AD, 32'h0);
    repeat (2) @(negedge clk);
    chk("irq_masked", irq, 32'h0);
    rdc("int_stat_masked", AS, 32'h3, 32'h2);
    apb(1'b1, AC, 32'h1);
  endtask

  // Misaligned and unmapped accesses are refused or read as zero.
  task t_bus;
    apb(1'b0, AF | 12'h001, 32'h0);
    chk("slverr", err, 32'h1);
    apb(1'b1, 12'h080, 32'hFF);
    rdc("unmapped", 12'h080, 32'hFFFFFFFF, 32'h0);
    chk("slverr_none", err, 32'h0);
    rdc("flags_same", AF, 32'hFF, 32'h08);
  endtask

  // Reset for 16 cycles, then the scenarios in turn.
  initial
  begin
    clk = 1'b0;
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    fails = 0;
    check_count = 0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    chk("nak_reset", force_nak, 32'h0);
    chk("irq_reset", irq, 32'h0);
    t_underrun();
    t_overrun();
    t_iso();
    t_irq();
    t_bus();
    report_and_stop();
  end
endmodule
